/* File: logic/cfid_addr_stack.sv */
// Address stack: flip-flop entries selected by a downward-growing stack pointer.
// Assumes push and pop are never asserted together; overflow simply wraps.
module cfid_addr_stack #(
  parameter int DEPTH = cfid_pkg::STACK_DEPTH,
  parameter int WIDTH = cfid_pkg::WORD_W,
  parameter int SP_W  = 3
) (
  input  wire logic  sys_clk,
  input  wire logic  reset,
  cfid_stack_if.stack sif
);
  logic [SP_W-1:0]  stack_pointer_q;
  logic [SP_W-1:0]  stack_pointer_d;
  logic [SP_W-1:0]  write_idx;
  logic [WIDTH-1:0] entry_q [DEPTH];

  always_comb
  begin
    stack_pointer_d = stack_pointer_q;
    write_idx = stack_pointer_q - SP_W'(1);
    if (sif.push)
      stack_pointer_d = write_idx;                       // [RULE1] [RULE8] [RULE9]
    else if (sif.pop)
      stack_pointer_d = stack_pointer_q + SP_W'(1);      // [RULE2] [RULE10] [RULE12]
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      stack_pointer_q <= SP_W'(DEPTH);                   // [RULE19]
    else
      stack_pointer_q <= stack_pointer_d;
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge sys_clk)
    begin
      if (sif.push && write_idx == SP_W'(i))
        entry_q[i] <= sif.wdata;
    end
  end

  // An empty or wrapped pointer reads as zero rather than an undefined entry
  assign sif.rdata = (stack_pointer_q < SP_W'(DEPTH)) ? entry_q[stack_pointer_q] : '0;
  assign sif.stack_pointer = stack_pointer_q;
endmodule

/* File: logic/cfid_core.sv */
// Decoder and executor for stack, control-file, peripheral, branch and control insns.
// Assumes the fetch unit holds insn_word while insn_valid is high and insn_ready low.
module cfid_core #(
  parameter int PC_WIDTH    = cfid_pkg::PC_W,
  parameter int STACK_DEPTH = cfid_pkg::STACK_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] insn_word,
  input  wire logic        insn_valid,
  output logic             insn_ready,
  output logic [PC_WIDTH-1:0] program_counter,
  output logic [15:0]      address_register,
  input  wire logic [15:0] table_rdata,
  output logic [PC_WIDTH-1:0] table_addr,
  output logic [6:0]       control_file_location,
  input  wire logic [3:0]  control_file_rdata,
  output logic             control_file_wr_en,
  output logic [3:0]       control_file_wdata,
  output logic [3:0]       window_register,
  output logic [6:0]       periph_addr,
  input  wire logic [15:0] periph_rdata,
  output logic             periph_rd_en,
  output logic             periph_wr_en,
  output logic [15:0]      periph_wdata,
  output logic [15:0]      data_buffer,
  output logic             irq_master_enable,
  input  wire logic [3:0]  irq_state_saved,
  output logic [3:0]       irq_state_live,
  output logic             skip_pending,
  output logic             stop_req,
  output logic             halt_req,
  output logic [3:0]       release_cond
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  cfid_stack_if #(.WIDTH(cfid_pkg::WORD_W), .SP_W(SP_W)) sif ();

  cfid_addr_stack #(.DEPTH(STACK_DEPTH), .WIDTH(cfid_pkg::WORD_W), .SP_W(SP_W)) u_stack (
    .sys_clk (sys_clk),
    .reset   (reset),
    .sif     (sif)
  );

  logic [4:0] op;
  logic [2:0] row;
  logic [3:0] sub;
  logic [3:0] low;
  logic       misc;
  logic       fire;
  assign op   = insn_word[cfid_pkg::OP_MSB:cfid_pkg::OP_LSB];
  assign row  = insn_word[cfid_pkg::ROW_MSB:cfid_pkg::ROW_LSB];
  assign sub  = insn_word[cfid_pkg::SUB_MSB:cfid_pkg::SUB_LSB];
  assign low  = insn_word[3:0];
  assign misc = (op == cfid_pkg::OP_MISC);

  cfid_pkg::cfid_state_t state_q, state_d;
  logic [PC_WIDTH-1:0] pc_q, pc_d, pc_next;
  logic [15:0] areg_q, areg_d, dbuf_q, dbuf_d, pwdata_q, pwdata_d;
  logic [3:0]  win_q, win_d, cfw_q, cfw_d, live_q, live_d, rel_q, rel_d;
  logic [6:0]  cfloc_q, cfloc_d, paddr_q, paddr_d;
  logic [PC_WIDTH-1:0] taddr_q, taddr_d;
  logic        ime_q, ime_d, skip_q, skip_d, cfwe_q, cfwe_d, pwe_q, pwe_d, pre_q, pre_d;
  logic        stop_q, stop_d, halt_q, halt_d;
  logic        push, pop;
  logic [15:0] push_data;

  // Only the first cycle of a table read takes an instruction
  assign insn_ready = (state_q == cfid_pkg::CFID_EXEC);   // [RULE17]
  assign fire       = insn_valid && insn_ready;
  assign pc_next    = pc_q + PC_WIDTH'(1);

  always_comb
  begin
    state_d  = state_q;
    pc_d     = pc_q;
    areg_d   = areg_q;
    dbuf_d   = dbuf_q;
    win_d    = win_q;
    live_d   = live_q;
    ime_d    = ime_q;
    skip_d   = skip_q;
    cfloc_d  = cfloc_q;
    cfw_d    = cfw_q;
    paddr_d  = paddr_q;
    pwdata_d = pwdata_q;
    taddr_d  = taddr_q;
    rel_d    = rel_q;
    cfwe_d   = 1'b0;
    pwe_d    = 1'b0;
    pre_d    = 1'b0;
    stop_d   = 1'b0;
    halt_d   = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    push_data = areg_q;
    unique case (state_q)
      cfid_pkg::CFID_TBL:
      begin
        dbuf_d  = table_rdata;
        state_d = cfid_pkg::CFID_EXEC;                     // [RULE17]
      end
      cfid_pkg::CFID_EXEC:
      begin
        if (fire && skip_q)
        begin
          // The skipped instruction is consumed like a no-operation
          skip_d = 1'b0;                                   // [RULE11]
          pc_d   = pc_next;
        end
        else if (fire)
        begin
          pc_d = pc_next;                                  // [RULE16] [RULE18]
          if (op == cfid_pkg::OP_JUMP)
            pc_d = insn_word[PC_WIDTH-1:0];                // [RULE7]
          else if (op == cfid_pkg::OP_CALL)
          begin
            push      = 1'b1;
            push_data = 16'(pc_q);
            pc_d      = insn_word[PC_WIDTH-1:0];           // [RULE8]
          end
          else if (misc)
          begin
            unique case (sub)
              cfid_pkg::SUB_PUSH:
                if (row == cfid_pkg::ROW_0 && low == cfid_pkg::LOW_ZERO)
                  push = 1'b1;                             // [RULE1]
              cfid_pkg::SUB_POP:
                if (row == cfid_pkg::ROW_0 && low == cfid_pkg::LOW_ZERO)
                begin
                  areg_d = sif.rdata;                      // [RULE2]
                  pop  = 1'b1;
                end
              cfid_pkg::SUB_CFRD:
              begin
                cfloc_d = {row, low};
                win_d   = control_file_rdata;              // [RULE3]
              end
              cfid_pkg::SUB_CFWR:
              begin
                cfloc_d = {row, low};
                cfw_d   = win_q;
                cfwe_d  = 1'b1;                            // [RULE4]
              end
              cfid_pkg::SUB_PERRD:
              begin
                paddr_d = {row, low};
                pre_d   = 1'b1;
                dbuf_d  = periph_rdata;                    // [RULE5]
              end
              cfid_pkg::SUB_PERWR:
              begin
                paddr_d  = {row, low};
                pwdata_d = dbuf_q;
                pwe_d    = 1'b1;                           // [RULE6]
              end
              cfid_pkg::SUB_JIND:
                if (row == cfid_pkg::ROW_0 && low == cfid_pkg::LOW_ZERO)
                  pc_d = areg_q[PC_WIDTH-1:0];             // [RULE7]
              cfid_pkg::SUB_CIND:
                if (row == cfid_pkg::ROW_0 && low == cfid_pkg::LOW_ZERO)
                begin
                  push      = 1'b1;
                  push_data = 16'(pc_q);
                  pc_d      = areg_q[PC_WIDTH-1:0];        // [RULE9]
                end
              cfid_pkg::SUB_TREAD:
                if (row == cfid_pkg::ROW_0 && low == cfid_pkg::LOW_ZERO)
                begin
                  taddr_d = areg_q[PC_WIDTH-1:0];
                  state_d = cfid_pkg::CFID_TBL;            // [RULE17]
                end
              cfid_pkg::SUB_RET:
                if (low == cfid_pkg::LOW_ZERO &&
                    (row == cfid_pkg::ROW_0 || row == cfid_pkg::ROW_1 ||
                     row == cfid_pkg::ROW_4))
                begin
                  pc_d = sif.rdata[PC_WIDTH-1:0];          // [RULE10]
                  pop  = 1'b1;
                  if (row == cfid_pkg::ROW_1)
                    skip_d = 1'b1;                         // [RULE11]
                  if (row == cfid_pkg::ROW_4)
                    live_d = irq_state_saved;              // [RULE12]
                end
              cfid_pkg::SUB_CTRL:
                unique case (row)
                  cfid_pkg::ROW_0: if (low == cfid_pkg::LOW_ZERO) ime_d = 1'b1;  // [RULE13]
                  cfid_pkg::ROW_1: if (low == cfid_pkg::LOW_ZERO) ime_d = 1'b0;  // [RULE13]
                  cfid_pkg::ROW_2:
                  begin
                    stop_d = 1'b1;                         // [RULE14]
                    rel_d  = low;
                  end
                  cfid_pkg::ROW_3:
                  begin
                    halt_d = 1'b1;                         // [RULE15]
                    rel_d  = low;
                  end
                  default: ;                               // [RULE16] [RULE18]
                endcase
              default: ;                                   // [RULE18]
            endcase
          end
        end
      end
      default: state_d = cfid_pkg::CFID_EXEC;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q  <= cfid_pkg::CFID_EXEC;
      pc_q     <= PC_WIDTH'(cfid_pkg::PC_RESET);           // [RULE19]
      ime_q    <= 1'b0;                                    // [RULE19]
      areg_q   <= 16'h0000;
      dbuf_q   <= 16'h0000;
      win_q    <= 4'h0;
      live_q   <= 4'h0;
      skip_q   <= 1'b0;
      cfloc_q  <= 7'h00;
      cfw_q    <= 4'h0;
      paddr_q  <= 7'h00;
      pwdata_q <= 16'h0000;
      taddr_q  <= '0;
      rel_q    <= 4'h0;
      cfwe_q   <= 1'b0;
      pwe_q    <= 1'b0;
      pre_q    <= 1'b0;
      stop_q   <= 1'b0;
      halt_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      ime_q    <= ime_d;
      areg_q   <= areg_d;
      dbuf_q   <= dbuf_d;
      win_q    <= win_d;
      live_q   <= live_d;
      skip_q   <= skip_d;
      cfloc_q  <= cfloc_d;
      cfw_q    <= cfw_d;
      paddr_q  <= paddr_d;
      pwdata_q <= pwdata_d;
      taddr_q  <= taddr_d;
      rel_q    <= rel_d;
      cfwe_q   <= cfwe_d;
      pwe_q    <= pwe_d;
      pre_q    <= pre_d;
      stop_q   <= stop_d;
      halt_q   <= halt_d;
    end
  end

  assign sif.push  = push;
  assign sif.pop   = pop;
  assign sif.wdata = push_data;

  // Read-side address is live so the addressed register answers in the same cycle
  assign control_file_location = fire ? {row, low} : cfloc_q;
  assign periph_addr           = fire ? {row, low} : paddr_q;
  assign table_addr            = taddr_q;
  assign program_counter       = pc_q;
  assign address_register      = areg_q;
  assign control_file_wr_en    = cfwe_q;
  assign control_file_wdata    = cfw_q;
  assign window_register       = win_q;
  assign periph_rd_en          = pre_q;
  assign periph_wr_en          = pwe_q;
  assign periph_wdata          = pwdata_q;
  assign data_buffer           = dbuf_q;
  assign irq_master_enable     = ime_q;
  assign irq_state_live        = live_q;
  assign skip_pending          = skip_q;
  assign stop_req              = stop_q;
  assign halt_req              = halt_q;
  assign release_cond          = rel_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic is_push, is_pop, is_call, is_irq_on, is_irq_off, is_tread, is_jump, is_cfwr;
  assign is_push  = fire && !skip_q && misc && sub == cfid_pkg::SUB_PUSH &&
                    row == 3'h0 && low == 4'h0;
  assign is_pop   = fire && !skip_q && misc && sub == cfid_pkg::SUB_POP &&
                    row == 3'h0 && low == 4'h0;
  assign is_call  = fire && !skip_q && op == cfid_pkg::OP_CALL;
  assign is_jump  = fire && !skip_q && op == cfid_pkg::OP_JUMP;
  assign is_irq_on  = fire && !skip_q && misc && sub == 4'hF && row == 3'h0 && low == 4'h0;
  assign is_irq_off = fire && !skip_q && misc && sub == 4'hF && row == 3'h1 && low == 4'h0;
  assign is_tread = fire && !skip_q && misc && sub == 4'h1 && row == 3'h0 && low == 4'h0;
  assign is_cfwr  = fire && !skip_q && misc && sub == cfid_pkg::SUB_CFWR;

  property p_push_sp;
    is_push |=> sif.stack_pointer == $past(sif.stack_pointer) - SP_W'(1);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push did not decrement pointer"); // [RULE1]

  property p_pop_areg;
    is_pop |=> areg_q == $past(sif.rdata) &&
               sif.stack_pointer == $past(sif.stack_pointer) + SP_W'(1);
  endproperty
  a_pop_areg: assert property (p_pop_areg) else $error("pop result wrong"); // [RULE2]

  property p_jump_pc;
    is_jump |=> pc_q == $past(insn_word[PC_WIDTH-1:0]);
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong"); // [RULE7]

  property p_call_save;
    is_call |=> sif.rdata == 16'($past(pc_q)) && pc_q == $past(insn_word[PC_WIDTH-1:0]);
  endproperty
  a_call_save: assert property (p_call_save) else $error("call did not save counter"); // [RULE8]

  property p_irq_on;
    is_irq_on |=> ime_q;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enable flag not set"); // [RULE13]

  property p_irq_off;
    is_irq_off |=> !ime_q;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("enable flag not cleared"); // [RULE13]

  property p_cfwr;
    is_cfwr |=> control_file_wr_en && control_file_wdata == $past(win_q);
  endproperty
  a_cfwr: assert property (p_cfwr) else $error("control write wrong"); // [RULE4]

  sequence s_tread_busy;
    !insn_ready ##1 insn_ready;
  endsequence
  property p_tread;
    is_tread |=> s_tread_busy ##0 data_buffer == $past(table_rdata);
  endproperty
  a_tread: assert property (p_tread) else $error("table read not two cycles"); // [RULE17]

  // Checked the edge after reset is sampled, so no history before the first edge is needed
  property p_reset;
    @(posedge sys_clk) disable iff (1'b0)
      reset |=> pc_q == '0 && !ime_q && sif.stack_pointer == SP_W'(STACK_DEPTH);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong"); // [RULE19]
endmodule

/* File: logic/cfid_pkg.sv */
// Constants for the control-flow instruction decoder: codes, fields, reset values.
// Assumes a 16-bit instruction word presented with a valid/ready handshake.
// How it works
// RULE1: push decrements stack pointer, then writes address register into selected entry.
// RULE2: pop loads address register from current entry, then increments stack pointer.
// RULE3: control-file read copies location row 10..8, column 3..0 into window.
// RULE4: control-file write copies window into the addressed control-file location.
// RULE5: peripheral read loads data buffer from peripheral at bits 10..8 and 3..0.
// RULE6: peripheral write sends data buffer to the addressed peripheral register.
// RULE7: jump sets program counter 9..0 from address field; indirect loads from address register.
// RULE8: direct call decrements pointer, saves program counter, loads address field.
// RULE9: indirect call decrements pointer, saves program counter, loads address register.
// RULE10: plain return restores program counter from stack, increments stack pointer.
// RULE11: return with skip acts as return and skips the instruction after.
// RULE12: interrupt return restores counter and live interrupt state, increments pointer.
// RULE13: irq on instruction sets master enable; irq off instruction clears it.
// RULE14: stop decodes at row 010, sub-code 1111, release condition in 3..0.
// RULE15: halt decodes at row 011, sub-code 1111, release condition in 3..0.
// RULE16: no-operation only advances the program counter.
// RULE17: table read takes two instruction cycles; all others take one.
// RULE18: undefined encodings execute as no-operation, leaving all state but the program counter unchanged.
// RULE19: reset clears program counter and master enable, stack pointer to empty.
package cfid_pkg;
  localparam logic [4:0] OP_MISC   = 5'h07;
  localparam logic [4:0] OP_JUMP   = 5'h0C;
  localparam logic [4:0] OP_CALL   = 5'h1C;
  localparam logic [3:0] SUB_TREAD = 4'h1;
  localparam logic [3:0] SUB_CFWR  = 4'h2;
  localparam logic [3:0] SUB_CFRD  = 4'h3;
  localparam logic [3:0] SUB_JIND  = 4'h4;
  localparam logic [3:0] SUB_CIND  = 4'h5;
  localparam logic [3:0] SUB_PERWR = 4'hA;
  localparam logic [3:0] SUB_PERRD = 4'hB;
  localparam logic [3:0] SUB_POP   = 4'hC;
  localparam logic [3:0] SUB_PUSH  = 4'hD;
  localparam logic [3:0] SUB_RET   = 4'hE;
  localparam logic [3:0] SUB_CTRL  = 4'hF;
  localparam logic [2:0] ROW_0     = 3'h0;
  localparam logic [2:0] ROW_1     = 3'h1;
  localparam logic [2:0] ROW_2     = 3'h2;
  localparam logic [2:0] ROW_3     = 3'h3;
  localparam logic [2:0] ROW_4     = 3'h4;
  localparam logic [3:0] LOW_ZERO  = 4'h0;
  localparam int         OP_MSB    = 15;
  localparam int         OP_LSB    = 11;
  localparam int         ROW_MSB   = 10;
  localparam int         ROW_LSB   = 8;
  localparam int         SUB_MSB   = 7;
  localparam int         SUB_LSB   = 4;
  localparam int         ADDR_MSB  = 9;
  localparam int         PC_W      = 10;
  localparam int         WORD_W    = 16;
  localparam int         STACK_DEPTH = 5;
  localparam int         TREAD_CYCLES = 2;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  typedef enum logic [1:0] {
    CFID_EXEC = 2'b01,
    CFID_TBL  = 2'b10
  } cfid_state_t;
endpackage

/* File: logic/cfid_stack_if.sv */
// Carrier between the decoder core and its address stack.
// Assumes both ends share sys_clk.
interface cfid_stack_if #(
  parameter int WIDTH = 16,
  parameter int SP_W  = 3
);
  logic             push;
  logic             pop;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] rdata;
  logic [SP_W-1:0]  stack_pointer;
  modport core  (output push, output pop, output wdata, input rdata, input stack_pointer);
  modport stack (input push, input pop, input wdata, output rdata, output stack_pointer);
endinterface

/* File: tb/control_flow_insn_decoder_tb_top.sv */
// Self-checking bench for cfid_core: the driver notes each expected state, the monitor compares.
// Assumes cfid_core with default parameters, a 100 ns sys_clk and a synchronous reset.
module control_flow_insn_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [9:0]  pc;
    logic [15:0] areg;
    logic [15:0] dbuf;
    logic [3:0]  win;
    logic        ime;
    logic [3:0]  live;
    logic        skip;
    logic        cf_wr;
    logic [3:0]  cf_wdata;
    logic        pw_en;
    logic [15:0] pwdata;
    logic        stop;
    logic        halt;
    logic [3:0]  rel;
  } cfid_snap_t;

  localparam logic [15:0] KINDS [23] = '{16'h38D0, 16'h38C0, 16'h3830, 16'h3820, 16'h38B0,
    16'h38A0, 16'h6000, 16'h3840, 16'hE000, 16'h3850, 16'hE000, 16'h38E0, 16'h39E0, 16'h3CF0,
    16'h3CE0, 16'h38F0, 16'h39F0, 16'h3AF0, 16'h3BF0, 16'h3CF0, 16'h3810, 16'h3890, 16'h38D1};

  logic        sys_clk;
  logic        reset              = 1'b1;
  logic [15:0] insn_word          = 16'h0000;
  logic        insn_valid         = 1'b0;
  logic [15:0] table_rdata        = 16'h0000;
  logic [3:0]  control_file_rdata = 4'h0;
  logic [15:0] periph_rdata       = 16'h0000;
  logic [3:0]  irq_state_saved    = 4'h0;
  logic        insn_ready;
  logic [9:0]  program_counter;
  logic [15:0] address_register;
  logic [9:0]  table_addr;
  logic [6:0]  control_file_location;
  logic        control_file_wr_en;
  logic [3:0]  control_file_wdata;
  logic [3:0]  window_register;
  logic [6:0]  periph_addr;
  logic        periph_rd_en;
  logic        periph_wr_en;
  logic [15:0] periph_wdata;
  logic [15:0] data_buffer;
  logic        irq_master_enable;
  logic [3:0]  irq_state_live;
  logic        skip_pending;
  logic        stop_req;
  logic        halt_req;
  logic [3:0]  release_cond;
  integer      seed               = 32'h7c1f5136;
  int          n_fail             = 0;
  int          checked            = 0;
  cfid_snap_t  m;
  cfid_snap_t  notes [$];
  logic [15:0] stk [0:7];
  int          stk_ptr;

  cfid_core dut_u (
    .sys_clk, .reset, .insn_word, .insn_valid, .insn_ready, .program_counter,
    .address_register, .table_rdata, .table_addr, .control_file_location,
    .control_file_rdata, .control_file_wr_en, .control_file_wdata, .window_register,
    .periph_addr, .periph_rdata, .periph_rd_en, .periph_wr_en, .periph_wdata, .data_buffer,
    .irq_master_enable, .irq_state_saved, .irq_state_live, .skip_pending, .stop_req,
    .halt_req, .release_cond
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic cfid_snap_t seen_now();
    return '{program_counter, address_register, data_buffer, window_register,
      irq_master_enable, irq_state_live, skip_pending, control_file_wr_en,
      control_file_wdata, periph_wr_en, periph_wdata, stop_req, halt_req, release_cond};
  endfunction

  function automatic void spush(input logic [15:0] v);
    stk_ptr = stk_ptr - 1;
    stk[stk_ptr] = v;
  endfunction

  function automatic logic [15:0] spop();
    spop = stk[stk_ptr];
    stk_ptr = stk_ptr + 1;
  endfunction

  // Stack grows downward: the saved counter is the call's own address
  function automatic logic [9:0] call_to(input logic [9:0] t);
    spush({6'h00, m.pc});
    return t;
  endfunction

  function automatic logic [15:0] op_mask(input logic [15:0] b);
    if (b[15:11] != cfid_pkg::OP_MISC) return 16'h03FF;
    if (b[7:4] inside {cfid_pkg::SUB_CFRD, cfid_pkg::SUB_CFWR, cfid_pkg::SUB_PERRD,
        cfid_pkg::SUB_PERWR}) return 16'h070F;
    if (b[7:4] == cfid_pkg::SUB_CTRL && b[10:9] == 2'b01) return 16'h000F;
    return 16'h0000;
  endfunction

  task automatic do_reset(input int n);
    reset = 1'b1;
    insn_valid = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 reset = 1'b0;
    m = '0;
    stk_ptr = cfid_pkg::STACK_DEPTH;
    foreach (stk[i]) stk[i] = 16'h0000;
  endtask

  task automatic issue(input logic [15:0] w);
    cfid_snap_t e;
    logic [2:0] row;
    logic [3:0] sub;
    logic [3:0] lo;
    logic       z0;
    logic       act;
    row = w[10:8];
    sub = w[7:4];
    lo = w[3:0];
    z0 = (lo == 4'h0) && (row == 3'h0);
    act = !m.skip && (w[15:11] == cfid_pkg::OP_MISC);
    insn_word = w;
    insn_valid = 1'b1;
    control_file_rdata = 4'($random(seed));
    periph_rdata = 16'($random(seed));
    table_rdata = 16'($random(seed));
    irq_state_saved = 4'($random(seed));
    e = m;
    {e.cf_wr, e.pw_en, e.stop, e.halt, e.skip} = 5'h00;
    e.pc = m.pc + 10'h001;
    if (!m.skip && w[15:11] == cfid_pkg::OP_JUMP) e.pc = w[9:0];
    if (!m.skip && w[15:11] == cfid_pkg::OP_CALL) e.pc = call_to(w[9:0]);
    if (act)
      case (sub)
        cfid_pkg::SUB_PUSH: if (z0) spush(m.areg);
        cfid_pkg::SUB_POP: if (z0) e.areg = spop();
        cfid_pkg::SUB_CFRD: e.win = control_file_rdata;
        cfid_pkg::SUB_CFWR: {e.cf_wr, e.cf_wdata} = {1'b1, m.win};
        cfid_pkg::SUB_PERRD: e.dbuf = periph_rdata;
        cfid_pkg::SUB_PERWR: {e.pw_en, e.pwdata} = {1'b1, m.dbuf};
        cfid_pkg::SUB_JIND: if (z0) e.pc = m.areg[9:0];
        cfid_pkg::SUB_CIND: if (z0) e.pc = call_to(m.areg[9:0]);
        cfid_pkg::SUB_TREAD: if (z0) e.dbuf = table_rdata;
        cfid_pkg::SUB_RET:
          if (lo == 4'h0 && row inside {3'h0, 3'h1, 3'h4})
          begin
            e.pc = 10'(spop());
            e.skip = (row == 3'h1);
            if (row == 3'h4) e.live = irq_state_saved;
          end
        cfid_pkg::SUB_CTRL:
          case (row)
            3'h0: if (lo == 4'h0) e.ime = 1'b1;
            3'h1: if (lo == 4'h0) e.ime = 1'b0;
            3'h2: {e.stop, e.rel} = {1'b1, lo};
            3'h3: {e.halt, e.rel} = {1'b1, lo};
            default: ;
          endcase
        default: ;
      endcase
    notes.push_back(e);
    m = e;
    #1;
    if (act && sub inside {cfid_pkg::SUB_CFRD, cfid_pkg::SUB_CFWR})
      check(80'(control_file_location), 80'({row, lo}));
    if (act && sub inside {cfid_pkg::SUB_PERRD, cfid_pkg::SUB_PERWR})
      check(80'(periph_addr), 80'({row, lo}));
    @(posedge sys_clk);
    #1;
    check(80'(insn_ready), 80'(!(act && z0 && sub == cfid_pkg::SUB_TREAD)));
    check(80'(periph_rd_en), 80'(act && sub == cfid_pkg::SUB_PERRD));
    if (act && z0 && sub == cfid_pkg::SUB_TREAD)
      check(80'(table_addr), 80'(m.areg[9:0]));
    while (insn_ready !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // Compares once the accepted instruction has finished, so a table read is seen after its stall
  initial
  begin
    cfid_snap_t s;
    cfid_snap_t e;
    forever
    begin
      @(posedge sys_clk);
      if (reset === 1'b0 && insn_valid === 1'b1 && insn_ready === 1'b1)
      begin
        @(negedge sys_clk);
        while (insn_ready !== 1'b1) @(negedge sys_clk);
        s = seen_now();
        e = (notes.size() > 0) ? notes.pop_front() : '1;
        // Write data only means something beside its strobe
        if (e.cf_wr !== 1'b1) s.cf_wdata = e.cf_wdata;
        if (e.pw_en !== 1'b1) s.pwdata = e.pwdata;
        check(s, e);
      end
    end
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    int          k;
    logic [15:0] w;
    logic        bad;
    do_reset(6);
    check(80'(insn_ready), 80'h1);
    check(seen_now(), '0);
    $display("test reset done");
    for (int i = 0; i < 23; i++) issue(KINDS[i] | (16'($random(seed)) & op_mask(KINDS[i])));
    $display("test directed done");
    for (int i = 0; i < 300; i++)
    begin
      k = $unsigned($random(seed)) % 23;
      w = KINDS[k] | (16'($random(seed)) & op_mask(KINDS[k]));
      // Overflow and underflow wrap unchecked, so keep the stack in range
      bad = (stk_ptr == 0) && (w == 16'h38D0 || w == 16'h3850 || w[15:11] == cfid_pkg::OP_CALL);
      bad = bad || ((stk_ptr == cfid_pkg::STACK_DEPTH) &&
                    (w == 16'h38C0 || w[15:4] inside {12'h38E, 12'h39E, 12'h3CE}));
      if (!bad) issue(w);
    end
    $display("test random done");
    issue(16'h38F0);
    issue(16'h6123);
    do_reset(2);
    check(seen_now(), '0);
    $display("test midrun reset done");
    repeat (2) @(posedge sys_clk);
    check(80'(notes.size()), 80'h0);
    close_out();
  end
endmodule
